// ==== core/pdmo_params.svh ====
`ifndef PDMO_PARAMS_SVH
`define PDMO_PARAMS_SVH
`define PDMO_CLK_HZ 10000000
`define PDMO_STARTUP_COARSE_MS 20
`define PDMO_STARTUP_FINE_MS 50
`define PDMO_MS_CYCLES(ms) ((ms) * (`PDMO_CLK_HZ / 1000))
`define PDMO_ACT_TIMEOUT 8'hff
`define PDMO_FIFO_DEPTH 8
`define PDMO_FIFO_AW 3
`define PDMO_PER_W 16
`define PDMO_OFS_LOW_DENS 16'h0001
`define PDMO_OFS_HIGH_DENS 16'h0052
`define PDMO_MODE_DELTA 16'h0020
`endif

// ==== core/pdmo_pkg.sv ====
package pdmo_pkg;
  typedef enum logic [1:0] {
    PDMO_IDLE_TONE,
    PDMO_COARSE,
    PDMO_FINE
  } pdmo_state_t;
endpackage

// ==== core/pdmo_fifo.sv ====
`timescale 1ns/10ps
module pdmo_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // write side
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [WIDTH-1:0] wdata_i,
  // read side
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg;
  logic [AW-1:0] rptr_reg;
  logic [AW:0] cnt_reg;
  logic wr_en;
  logic rd_en;

  assign wready_o = (cnt_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign rvalid_o = (cnt_reg != '0) ? 1'b1 : 1'b0;
  assign rdata_o = mem[rptr_reg];
  assign wr_en = wvalid_i & wready_o;
  assign rd_en = rvalid_o & rready_i;

  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      mem[wptr_reg] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (wr_en) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
      end
      if (rd_en) begin
        rptr_reg <= (rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
    end
  end
endmodule

// ==== core/pdmo_core.sv ====
`timescale 1ns/10ps
`include "pdmo_params.svh"
// Summary of operation
// - select low drives after fall, else rise
// - startup settles by 20 ms, 50 ms
// - clock mode change restarts settling timers
// - idle tone until signal is valid
// - select level latched at start sets offset
// - offset constant, independent of audio amplitude
// - at most two devices alternate per period
// - mode follows shared clock frequency
// - clock in, data out, select slot
module pdmo_core #(
  parameter int COARSE_CYC = `PDMO_MS_CYCLES(`PDMO_STARTUP_COARSE_MS),
  parameter int FINE_CYC = `PDMO_MS_CYCLES(`PDMO_STARTUP_FINE_MS)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // pdm link pins, sampled on clk_i
  input wire logic pdm_clk_i,
  input wire logic select_i,
  output logic pdm_data_o,
  output logic pdm_data_oen_o,
  // audio source samples, one bit per pdm period
  input wire logic audio_valid_i,
  input wire logic audio_bit_i,
  output logic audio_ready_o,
  // status
  output logic settled_coarse_o,
  output logic settled_fine_o,
  output logic [1:0] mode_o
);
  logic clk_d_reg;
  logic rise;
  logic fall;
  logic drive_edge;
  logic release_edge;
  logic clk_seen_reg;
  logic sel_reg;
  logic sel_locked_reg;
  logic [`PDMO_PER_W-1:0] per_cnt_reg;
  logic [`PDMO_PER_W-1:0] per_reg;
  logic [1:0] mode_next;
  logic [1:0] mode_reg;
  logic [31:0] settle_reg;
  logic [7:0] idle_reg;
  logic [15:0] acc_reg;
  logic [15:0] offset;
  logic [16:0] acc_sum;
  logic out_bit;
  logic fifo_rvalid;
  logic fifo_bit;
  pdmo_pkg::pdmo_state_t state_reg;

  assign rise = pdm_clk_i & ~clk_d_reg;
  assign fall = ~pdm_clk_i & clk_d_reg;
  assign drive_edge = sel_reg ? rise : fall;
  assign release_edge = sel_reg ? fall : rise;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_d_reg <= 1'b0;
    end else begin
      clk_d_reg <= pdm_clk_i;
    end
  end

  // slot and offset chosen once at startup, later select changes ignored
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sel_reg <= 1'b0;
      sel_locked_reg <= 1'b0;
    end else if (!sel_locked_reg) begin
      sel_reg <= select_i;
      sel_locked_reg <= 1'b1;
    end
  end

  // period measure selects the power mode; long gap means clock stopped
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      per_cnt_reg <= '0;
      per_reg <= '1;
      clk_seen_reg <= 1'b0;
    end else if (rise) begin
      // count stops one short of the edge-to-edge period, so add the capture cycle
      per_reg <= per_cnt_reg + 1'b1;
      per_cnt_reg <= '0;
      clk_seen_reg <= 1'b1;
    end else if (per_cnt_reg != 16'(`PDMO_ACT_TIMEOUT)) begin
      per_cnt_reg <= per_cnt_reg + 1'b1;
    end else begin
      clk_seen_reg <= 1'b0;
    end
  end

  // at 10 MHz sampling: >=3 MHz band ~3 cyc, 2.4 ~4, 1.5 ~6, 768k ~13
  always_comb begin
    if (per_reg < 16'h0004) begin
      mode_next = 2'h3;
    end else if (per_reg < 16'h0005) begin
      mode_next = 2'h2;
    end else if (per_reg < 16'h0009) begin
      mode_next = 2'h1;
    end else begin
      mode_next = 2'h0;
    end
  end

  // settling timers restart on clock loss or mode change
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_reg <= 2'h0;
      settle_reg <= '0;
      state_reg <= pdmo_pkg::PDMO_IDLE_TONE;
    end else if (!clk_seen_reg) begin
      settle_reg <= '0;
      state_reg <= pdmo_pkg::PDMO_IDLE_TONE;
    end else if (rise && mode_next != mode_reg) begin
      mode_reg <= mode_next;
      settle_reg <= '0;
      state_reg <= pdmo_pkg::PDMO_IDLE_TONE;
    end else begin
      case (state_reg)
        pdmo_pkg::PDMO_IDLE_TONE: begin
          settle_reg <= settle_reg + 1'b1;
          if (settle_reg >= 32'(COARSE_CYC - 1)) begin
            state_reg <= pdmo_pkg::PDMO_COARSE;
          end
        end
        pdmo_pkg::PDMO_COARSE: begin
          settle_reg <= settle_reg + 1'b1;
          if (settle_reg >= 32'(FINE_CYC - 1)) begin
            state_reg <= pdmo_pkg::PDMO_FINE;
          end
        end
        pdmo_pkg::PDMO_FINE: begin
          settle_reg <= settle_reg;
        end
        default: begin
          state_reg <= pdmo_pkg::PDMO_IDLE_TONE;
        end
      endcase
    end
  end

  // idle tone: fixed half-density pattern with no audio content
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idle_reg <= 8'h5a;
    end else if (drive_edge) begin
      idle_reg <= {idle_reg[6:0], idle_reg[7]};
    end
  end

  // fixed offset density added by first-order modulator, amplitude independent
  assign offset = sel_reg ? `PDMO_OFS_HIGH_DENS : `PDMO_OFS_LOW_DENS;
  assign acc_sum = {1'b0, acc_reg} + {1'b0, offset};
  assign out_bit = (state_reg == pdmo_pkg::PDMO_IDLE_TONE) ? idle_reg[7] :
                   ((fifo_rvalid ? fifo_bit : 1'b0) ^ acc_sum[16]);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_reg <= '0;
    end else if (drive_edge) begin
      acc_reg <= acc_sum[15:0];
    end
  end

  // drive on own edge, release on the other, so two devices share the line
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pdm_data_o <= 1'b0;
      pdm_data_oen_o <= 1'b1;
    end else if (drive_edge) begin
      pdm_data_o <= out_bit;
      pdm_data_oen_o <= 1'b0;
    end else if (release_edge || !clk_seen_reg) begin
      // a stopped clock frees the line; the first edge after a stop still drives
      pdm_data_oen_o <= 1'b1;
    end
  end

  // status trails the state by one cycle
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      settled_coarse_o <= 1'b0;
      settled_fine_o <= 1'b0;
    end else begin
      settled_coarse_o <= (state_reg != pdmo_pkg::PDMO_IDLE_TONE) ? 1'b1 : 1'b0;
      settled_fine_o <= (state_reg == pdmo_pkg::PDMO_FINE) ? 1'b1 : 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_o <= 2'h0;
    end else begin
      mode_o <= mode_reg;
    end
  end

  // audio waits here through the idle tone; a full fifo holds the source off
  pdmo_fifo #(
    .WIDTH(1),
    .DEPTH(`PDMO_FIFO_DEPTH),
    .AW(`PDMO_FIFO_AW)
  ) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .wvalid_i(audio_valid_i),
    .wready_o(audio_ready_o),
    .wdata_i(audio_bit_i),
    .rvalid_o(fifo_rvalid),
    .rready_i(drive_edge && state_reg != pdmo_pkg::PDMO_IDLE_TONE),
    .rdata_o(fifo_bit)
  );
endmodule

// ==== bench/pdmo_core_properties.sv ====
`timescale 1ns/10ps
module pdmo_core_properties #(
  parameter int COARSE_CYC = 400,
  parameter int FINE_CYC = 1000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // link and status
  input wire logic pdm_clk_i,
  input wire logic select_i,
  input wire logic pdm_data_o,
  input wire logic pdm_data_oen_o,
  input wire logic audio_ready_o,
  input wire logic settled_coarse_o,
  input wire logic settled_fine_o,
  input wire logic [1:0] mode_o
);
  int run_cnt;
  int gap;
  logic pclk_q;
  logic [7:0] idle_cnt;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) run_cnt <= 0;
    else run_cnt <= run_cnt + 1;
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) gap <= 0;
    else if ($rose(settled_coarse_o)) gap <= 0;
    else gap <= gap + 1;
  end
  // saturates so a stopped clock keeps the check armed
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pclk_q <= 1'b0;
      idle_cnt <= 8'h00;
    end else begin
      pclk_q <= pdm_clk_i;
      idle_cnt <= (pdm_clk_i != pclk_q) ? 8'h00 : idle_cnt + {7'h00, idle_cnt != 8'hff};
    end
  end
  property p_fall; $fell(pdm_clk_i) |-> ##[1:3] (pdm_data_oen_o == select_i); endproperty
  a_fall: assert property (p_fall) else $error("enable wrong after fall");
  property p_rise; $rose(pdm_clk_i) |-> ##[1:3] (pdm_data_oen_o != select_i); endproperty
  a_rise: assert property (p_rise) else $error("enable wrong after rise");
  property p_hold; !pdm_data_oen_o ##1 !pdm_data_oen_o |-> $stable(pdm_data_o); endproperty
  a_hold: assert property (p_hold) else $error("data moved while driven");
  property p_coarse; $rose(settled_coarse_o) |-> run_cnt >= COARSE_CYC; endproperty
  a_coarse: assert property (p_coarse) else $error("coarse settle early");
  property p_fine;
    $rose(settled_fine_o) |-> settled_coarse_o && gap inside {[FINE_CYC-COARSE_CYC-3:FINE_CYC-COARSE_CYC+3]};
  endproperty
  a_fine: assert property (p_fine) else $error("fine settle off");
  property p_mode; $changed(mode_o) |-> ##[0:3] !settled_coarse_o; endproperty
  a_mode: assert property (p_mode) else $error("mode change kept settle");
  property p_idle; !audio_ready_o && !settled_coarse_o ##1 audio_ready_o |-> ##[0:2] settled_coarse_o; endproperty
  a_idle: assert property (p_idle) else $error("audio used before settle");
  property p_lost; idle_cnt == 8'hff |-> ##3 (pdm_data_oen_o && !settled_coarse_o); endproperty
  a_lost: assert property (p_lost) else $error("stopped clock still driven");
endmodule
bind pdmo_core pdmo_core_properties #(.COARSE_CYC(COARSE_CYC), .FINE_CYC(FINE_CYC)) i_props (.*);

// ==== bench/pdmo_host_model.sv ====
`timescale 1ns/10ps
module pdmo_host_model (
  // clock and control
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [3:0] half_i,
  input wire logic select_i,
  // link
  input wire logic pdm_data_i,
  input wire logic pdm_data_oen_i,
  output logic pdm_clk_o,
  output logic bit_o,
  output logic bit_stb_o
);
  logic [3:0] cnt;
  logic last;
  // released line shows the inverse, never a stale level
  wire line = pdm_data_oen_i ? !last : pdm_data_i;
  initial begin
    pdm_clk_o = 1'b0;
    bit_o = 1'b0;
    bit_stb_o = 1'b0;
    cnt = 4'h0;
    last = 1'b0;
  end
  always @(posedge clk_i) begin
    if (!pdm_data_oen_i) last <= pdm_data_i;
    bit_stb_o <= 1'b0;
    if (!run_i) begin
      cnt <= 4'h0;
      pdm_clk_o <= 1'b0;
    end else if (cnt >= half_i - 4'h1) begin
      cnt <= 4'h0;
      pdm_clk_o <= !pdm_clk_o;
      if (pdm_clk_o == select_i) begin
        bit_o <= line;
        bit_stb_o <= 1'b1;
      end
    end else cnt <= cnt + 4'h1;
  end
endmodule

// ==== bench/pdm_mic_channel_output_tb.sv ====
`timescale 1ns/10ps
`include "pdmo_params.svh"
module pdm_mic_channel_output_tb;
  logic clk_i, rstn_i, select_i, audio_valid_i, audio_bit_i, run, feed, acc, m;
  logic [3:0] half;
  wire pdm_clk_i, pdm_data_o, pdm_data_oen_o, audio_ready_o, settled_coarse_o, settled_fine_o, rx_bit, rx_stb;
  wire [1:0] mode_o;
  logic [31:0] seed = 32'h26999328;
  int fail_count, check_count, k, i, n, ones, exp;
  logic q_tx[$];
  logic q_rx[$];
  pdmo_core #(.COARSE_CYC(400), .FINE_CYC(1000)) i_dut (.*);
  pdmo_host_model i_host (.clk_i, .run_i(run), .half_i(half), .select_i, .pdm_data_i(pdm_data_o),
    .pdm_data_oen_i(pdm_data_oen_o), .pdm_clk_o(pdm_clk_i), .bit_o(rx_bit), .bit_stb_o(rx_stb));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic restart(input logic sel, input logic fd);
    rstn_i = 1'b0;
    run = 1'b0;
    select_i = sel;
    feed = fd;
    repeat (8) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    q_tx.delete();
    q_rx.delete();
    run = 1'b1;
  endtask
  task automatic wait_for(input logic fine_sel, input int lim);
    for (k = 0; k < lim && (fine_sel ? settled_fine_o : settled_coarse_o) !== 1'b1; k++) @(posedge clk_i);
    #2 check(fine_sel ? settled_fine_o : settled_coarse_o, 1'b1);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // valid stays up until taken; fast feed keeps the fifo full
  always @(posedge clk_i) begin
    acc = audio_valid_i && audio_ready_o;
    if (acc) q_tx.push_back(audio_bit_i);
    if (rx_stb) q_rx.push_back(rx_bit);
    #1;
    if (!audio_valid_i || acc) begin
      seed = lfsr(seed);
      audio_valid_i = feed && (seed[0] || seed[1]);
      audio_bit_i = seed[7];
    end
  end
  initial begin
    #4000000;
    fail_count++;
    tally_and_finish;
  end
  initial begin
    half = 4'h4;
    audio_valid_i = 1'b0;
    audio_bit_i = 1'b0;
    restart(1'b0, 1'b1);
    repeat (300) @(posedge clk_i);
    #2 check(audio_ready_o, 1'b0);
    wait_for(1'b0, 250);
    n = q_rx.size();
    repeat (600) @(posedge clk_i);
    ones = 0;
    for (k = n - 12; k < n - 4; k++) ones += q_rx[k];
    check(ones, 4);
    ones = 0;
    for (k = n - 3; k <= n + 3; k++) begin
      m = 1'b1;
      for (i = 0; i < 32; i++) if (q_rx[k+i] !== q_tx[i]) m = 1'b0;
      if (m) ones = 1;
    end
    check(ones, 1);
    wait_for(1'b1, 100);
    restart(1'b1, 1'b0);
    wait_for(1'b0, 600);
    check(mode_o, 2'h1);
    n = q_rx.size();
    repeat (16384) @(posedge clk_i);
    ones = 0;
    for (k = n; k < n + 2000; k++) ones += q_rx[k];
    exp = (2000 * `PDMO_OFS_HIGH_DENS) >> 16;
    check(ones >= exp && ones <= exp + 1, 1'b1);
    #1 half = 4'h2;
    repeat (40) @(posedge clk_i);
    #2 check(mode_o, 2'h2);
    check(settled_coarse_o, 1'b0);
    wait_for(1'b0, 600);
    @(posedge clk_i);
    #1 half = 4'h1;
    repeat (40) @(posedge clk_i);
    #2 check(mode_o, 2'h3);
    check(settled_coarse_o, 1'b0);
    run = 1'b0;
    repeat (300) @(posedge clk_i);
    #2 check(pdm_data_oen_o, 1'b1);
    check(settled_coarse_o, 1'b0);
    tally_and_finish;
  end
endmodule
